// ---- common/ssra_if.sv ----
// Purpose: Four-wire serial link between host and sensor register access.
// Assumes: The bench passes the data-out wire straight to the host, ignoring its enable.
// Notes:   The device drives data-out at all times; its enable is high while its synchronised chip select is low.
`timescale 1ns/1ps
interface ssra_if;
  logic cs_n;       // Chip select, active low.
  logic sclk;       // Serial clock from host.
  logic mosi;       // Host to device data.
  logic miso;       // Device to host data value.
  logic miso_oe;    // Device drives data-out while high.

  modport host (output cs_n, output sclk, output mosi, input miso);
  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe);
endinterface : ssra_if

// ---- common/ssra_pkg.sv ----
// Purpose: Shared constants and types for the sensor serial register access link.
// Assumes: Both ends run on a 250 MHz system clock; the serial clock idles low.
// Notes:   Serial mode is clock idle low, sample on rising edge, shift on falling edge.
//
// What this block does
// RL1: Registers are 16 bits, two 6-bit byte addresses.
// RL2: Low chip select brackets one or more frames.
// RL3: Chip select high: output released, inputs ignored.
// RL4: Every frame is exactly 16 serial clocks.
// RL5: Full duplex, 16 bits each way per frame.
// RL6: Write frame: 1, 0, address, data byte.
// RL7: Host writes two frames for a full register.
// RL8: Read request: 0, 0, then 6-bit address.
// RL9: Last eight bits of read are ignored.
// RL10: Either byte address returns whole register.
// RL11: Read data shifts out in next frame.
// RL12: Output registers refresh at sample rate always.
// RL13: Bit 15 new data, bit 14 error alarm.
// RL14: New-data flag sets on refresh, clears on read.
// RL15: Error flag follows present alarm condition.
// RL16: 12-bit outputs: bits 13 and 12 don't care.
// RL17: Rate is 14-bit two's complement, 0x1FFF..0x2000.
// RL18: Rate LSB weight depends on selected range.
// RL19: Flash write counter is plain 16-bit at 0x00.
// RL20: Angle clears on null, soft reset, power-up.
// RL21: Most significant bit first; chip select held per frame.
package ssra_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned ADDR_BITS     = 6;
  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned CMD_WRITE_POS = 15;
  localparam int unsigned CMD_ZERO_POS  = 14;
  localparam int unsigned ADDR_LSB      = 8;

  // ----------------------------------------------------------------------
  // Output register byte addresses (lower byte of each pair)
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_FLASH_WRITE_COUNT = 6'h00;
  localparam logic [5:0] ADDR_SUPPLY_VOLTAGE    = 6'h02;
  localparam logic [5:0] ADDR_RATE              = 6'h04;
  localparam logic [5:0] ADDR_AUX_INPUT         = 6'h0a;
  localparam logic [5:0] ADDR_TEMPERATURE       = 6'h0c;
  localparam logic [5:0] ADDR_ANGLE             = 6'h0e;

  // ----------------------------------------------------------------------
  // Output word fields
  // ----------------------------------------------------------------------
  localparam int unsigned NEW_DATA_POS    = 15;
  localparam int unsigned ERROR_ALARM_POS = 14;
  localparam int unsigned DATA14_BITS     = 14;
  localparam int unsigned DATA12_BITS     = 12;
  localparam logic [13:0] RATE_MAX_CODE   = 14'h1fff;
  localparam logic [13:0] RATE_MIN_CODE   = 14'h2000;
  localparam logic [15:0] WORD_RESET      = 16'h0000;

  // Rate LSB weight in micro-degrees per second for each range.
  localparam int unsigned RATE_LSB_WIDE_UDPS   = 73260;
  localparam int unsigned RATE_LSB_MIDDLE_UDPS = RATE_LSB_WIDE_UDPS / 2;
  localparam int unsigned RATE_LSB_NARROW_UDPS = RATE_LSB_WIDE_UDPS / 4;

  // ----------------------------------------------------------------------
  // Host timing: serial clock period 80 ns made from the 4 ns system clock
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_PERIOD_PS   = 4000;
  localparam int unsigned SCLK_PERIOD_NS  = 80;
  localparam int unsigned SCLK_HALF_CYC   = (SCLK_PERIOD_NS * 1000 / SYS_PERIOD_PS) / 2;
  localparam int unsigned CS_GAP_NS       = 160;
  localparam int unsigned CS_GAP_CYC      = (CS_GAP_NS * 1000 + SYS_PERIOD_PS - 1)
                                            / SYS_PERIOD_PS;

  // Host command opcodes.
  typedef enum logic [1:0] {
    SSRA_OP_READ  = 2'b00,
    SSRA_OP_WRITE = 2'b01,
    SSRA_OP_FLUSH = 2'b10
  } ssra_op_t;

endpackage : ssra_pkg

// ---- testbench/ssra_link_sva.sv ----
// Purpose: Concurrent checks on the serial link between host and device ends.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Sees only the interface wires, never the user-side ports.
`timescale 1ns/1ps
module ssra_link_sva
  import ssra_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  logic       sclk_q;
  logic       cs_q;
  logic [4:0] rise_cnt;
  logic [5:0] high_cnt;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  // Counts serial clock rises in a frame and idle cycles between frames.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      rise_cnt <= 5'h00;
      high_cnt <= 6'h3f;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      if (!cs_n && cs_q) begin
        rise_cnt <= 5'h00;
      end else if (!cs_n && sclk && !sclk_q) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
      if (!cs_n) begin
        high_cnt <= 6'h00;
      end else if (high_cnt != 6'h3f) begin
        high_cnt <= high_cnt + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  chk_frame_clocks: assert property ($rose(cs_n) |-> rise_cnt == 5'h10)
    else $error("frame did not hold sixteen serial clocks");
  chk_frame_gap: assert property ($fell(cs_n) |-> high_cnt >= CS_GAP_CYC)
    else $error("chip select gap between frames too short");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock not idle low outside a frame");
  chk_sclk_half: assert property ($rose(sclk) |-> ##10 $fell(sclk))
    else $error("serial clock high phase not ten cycles");
  chk_release_idle: assert property (cs_n [*5] |-> !miso_oe)
    else $error("data out driven while chip select high");
  chk_drive_frame: assert property (!cs_n [*5] |-> miso_oe)
    else $error("data out not driven inside a frame");
  chk_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("host data changed at sampling edge");
  chk_miso_steady: assert property ($rose(sclk) && miso_oe |-> $stable(miso))
    else $error("device data changed at sampling edge");

  // Main traffic seen on the wire.
  cov_frame_end: cover property ($rose(cs_n));
  cov_release: cover property ($fell(miso_oe));
  cov_write_bit: cover property ($rose(sclk) && mosi);
endmodule : ssra_link_sva

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench joining the host and device ends of the link.
// Assumes: Host makes the serial clock; the bench drives both user sides.
// Notes:   Reads are pipelined, so each reply belongs to the previous read.
`timescale 1ns/1ps
module testbench
  import ssra_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam logic [5:0]  RA [6] = '{6'h05, 6'h00, 6'h03, 6'h0b, 6'h0c, 6'h3c};
  localparam logic [15:0] RE [6] = '{16'hdfff, 16'hbeef, 16'hcabc, 16'hc123, 16'hc456, 16'h0000};
  localparam logic [15:0] RM [6] = '{16'hffff, 16'hffff, 16'hcfff, 16'hcfff, 16'hcfff, 16'hffff};
  logic        clk_sys_in, resetn_in, cmd_valid, sample_strobe, error_alarm, angle_clear;
  logic [1:0]  cmd_op;
  logic [5:0]  cmd_addr;
  logic [7:0]  cmd_data;
  logic [11:0] supply, aux, temperature;
  logic [13:0] rate;
  logic [15:0] flash, r;
  wire         cmd_ready, reply_valid, wr_strobe;
  wire  [15:0] reply_data;
  wire  [5:0]  wr_addr;
  wire  [7:0]  wr_data;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          wr_cnt     = 0;

  ssra_if link_if();
  ssra_host ssra_host_inst (.clk_sys_in, .resetn_in, .link(link_if.host),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
    .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .reply_data_out(reply_data),
    .reply_valid_out(reply_valid));
  ssra_device ssra_device_inst (.clk_sys_in, .resetn_in, .link(link_if.device),
    .sample_strobe_in(sample_strobe), .supply_sample_in(supply), .rate_sample_in(rate),
    .aux_sample_in(aux), .temperature_sample_in(temperature), .error_alarm_in(error_alarm),
    .angle_clear_in(angle_clear), .flash_write_count_in(flash), .write_addr_out(wr_addr),
    .write_data_out(wr_data), .write_strobe_out(wr_strobe));
  ssra_link_sva ssra_link_sva_inst (.clk_sys_in, .resetn_in, .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .mosi(link_if.mosi), .miso(link_if.miso),
    .miso_oe(link_if.miso_oe));

  // System clock of 4 ns.
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Counts register writes decoded by the device.
  always @(posedge clk_sys_in) begin
    if (wr_strobe === 1'b1) wr_cnt++;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Issues one command and returns the word received during its frame.
  task automatic do_cmd(input logic [1:0] op, input logic [5:0] addr, input logic [7:0] data,
                        output logic [15:0] reply);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= addr;
    cmd_data  <= data;
    do @(posedge clk_sys_in); while (cmd_ready !== 1'b1 && ++n < 2000);
    cmd_valid <= 1'b0;
    n = 0;
    do @(posedge clk_sys_in); while (reply_valid !== 1'b1 && ++n < 2000);
    check("reply valid", 16'(reply_valid), 16'h0001);
    reply = reply_data;
  endtask

  // Loads new samples with a one-cycle strobe.
  task automatic strobe(input logic [13:0] rt, input logic alarm);
    rate          <= rt;
    error_alarm   <= alarm;
    sample_strobe <= 1'b1;
    @(posedge clk_sys_in);
    sample_strobe <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Two byte writes fill both halves of one register.
  task automatic test_write();
    int n;
    for (int i = 0; i < 2; i++) begin
      do_cmd(SSRA_OP_WRITE, 6'h14 + 6'(i), i ? 8'hc3 : 8'h5a, r);
      n = 0;
      while (wr_cnt != i + 1 && n < 50) begin
        @(posedge clk_sys_in);
        n++;
      end
      check("write count", 16'(wr_cnt), 16'(i + 1));
      check("write addr", {10'h000, wr_addr}, {10'h000, 6'h14 + 6'(i)});
      check("write data", {8'h00, wr_data}, {8'h00, i ? 8'hc3 : 8'h5a});
    end
  endtask

  // Pipelined reads of every output word except the angle, then of an unmapped address, then the flag clears after a read.
  task automatic test_reads();
    strobe(14'h1fff, 1'b1);
    do_cmd(SSRA_OP_READ, RA[0], 8'hff, r);
    for (int i = 1; i < 6; i++) begin
      do_cmd(SSRA_OP_READ, RA[i], 8'ha5, r);
      check("read word", r & RM[i-1], RE[i-1]);
    end
    do_cmd(SSRA_OP_READ, 6'h04, 8'h00, r);
    check("unmapped word", r, RE[5]);
    do_cmd(SSRA_OP_READ, 6'h00, 8'h00, r);
    check("rate reread", r, 16'h5fff);
  endtask

  // A fresh sample sets the flag again and carries the most negative code.
  task automatic test_refresh();
    strobe(14'h2000, 1'b0);
    do_cmd(SSRA_OP_READ, 6'h05, 8'h00, r);
    do_cmd(SSRA_OP_READ, 6'h00, 8'h00, r);
    check("rate refresh", r, 16'ha000);
  endtask

  // Clearing the angle leaves a zero value.
  task automatic test_angle();
    angle_clear <= 1'b1;
    @(posedge clk_sys_in);
    angle_clear <= 1'b0;
    @(posedge clk_sys_in);
    do_cmd(SSRA_OP_READ, 6'h0e, 8'h00, r);
    do_cmd(SSRA_OP_READ, 6'h00, 8'h00, r);
    check("angle value", r, 16'h8000);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    {cmd_valid, sample_strobe, error_alarm, angle_clear} = 4'h0;
    {cmd_op, cmd_addr, cmd_data} = 16'h0000;
    {supply, aux, temperature} = {12'habc, 12'h123, 12'h456};
    rate  = 14'h0000;
    flash = 16'hbeef;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    test_write();
    test_reads();
    test_refresh();
    test_angle();
    stop_test();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    #80000;
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    stop_test();
  end
endmodule : testbench

// ---- verilog/ssra_device.sv ----
// Purpose: Serial slave that exposes the sensor output data registers.
// Assumes: Serial clock idles low; inputs are synchronised to clk_sys_in.
// Notes:   Sample values, alarm and flash count arrive as user-side inputs.
//          A read reply leaves on the frame after its request, so a burst
//          of reads needs one extra frame at its end to drain the last word.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module ssra_device
  import ssra_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  ssra_if.device           link,
  input  wire logic        sample_strobe_in,
  input  wire logic [11:0] supply_sample_in,
  input  wire logic [13:0] rate_sample_in,
  input  wire logic [11:0] aux_sample_in,
  input  wire logic [11:0] temperature_sample_in,
  input  wire logic        error_alarm_in,
  input  wire logic        angle_clear_in,
  input  wire logic [15:0] flash_write_count_in,
  // Decoded byte writes for the register file that sits outside.
  output logic [5:0]       write_addr_out,
  output logic [7:0]       write_data_out,
  output logic             write_strobe_out
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  // Every register of the slave lives here: pin synchronisers, the frame
  // shifters, the five output values with their new-data flags, and the
  // decoded write. The frame position counts rising serial clock edges.
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  sclk_sync;
    logic [1:0]  mosi_sync;
    logic [4:0]  bit_count;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic        miso;
    logic [13:0] supply;
    logic [13:0] rate;
    logic [13:0] aux;
    logic [13:0] temperature;
    logic [13:0] angle;
    logic [4:0]  new_data;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_strobe;
  } ssra_dev_state_t;

  ssra_dev_state_t state;
  ssra_dev_state_t next_state;

  // Pin events, all taken from the second synchroniser stage or later.
  logic cs_active;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic [15:0] word_in;

  // ----------------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------------
  // Edges are found between the second and third serial clock stages, so
  // the first stage never feeds logic. Data in is taken from its second
  // stage, which lines up with the same edge of the serial clock.
  // A chip select that is high masks every serial clock edge.
  assign cs_active  = ~state.cs_sync[1];                              // RL2
  assign sclk_rise  = cs_active & state.sclk_sync[1] & ~state.sclk_sync[2]; // RL3
  assign sclk_fall  = cs_active & ~state.sclk_sync[1] & state.sclk_sync[2];
  assign word_in    = {state.shift_in[14:0], state.mosi_sync[1]};     // RL21
  assign frame_done = sclk_rise & (state.bit_count == 5'(FRAME_BITS - 1)); // RL4

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  // Either byte address of a pair selects the whole word, so address bit 0
  // is dropped. Unmapped addresses read as zero rather than stale data.
  function automatic logic [15:0] read_mux(input ssra_dev_state_t s, input logic [5:0] a);
    logic [5:0] base;
    base = {a[5:1], 1'b0};                                            // RL10 RL1
    unique case (base)
      ADDR_FLASH_WRITE_COUNT: read_mux = flash_write_count_in;        // RL19
      ADDR_SUPPLY_VOLTAGE:    read_mux = {s.new_data[0], error_alarm_in, s.supply}; // RL13 RL15
      ADDR_RATE:              read_mux = {s.new_data[1], error_alarm_in, s.rate}; // RL17
      ADDR_AUX_INPUT:         read_mux = {s.new_data[2], error_alarm_in, s.aux};
      ADDR_TEMPERATURE:       read_mux = {s.new_data[3], error_alarm_in, s.temperature};
      ADDR_ANGLE:             read_mux = {s.new_data[4], error_alarm_in, s.angle};
      default:                read_mux = WORD_RESET;
    endcase
  endfunction

  // Returns which new-data flag a read address owns, one-hot. The flash
  // write counter has no flag, so it owns none.
  function automatic logic [4:0] read_hit(input logic [5:0] a);
    logic [5:0] base;
    base = {a[5:1], 1'b0};
    unique case (base)
      ADDR_SUPPLY_VOLTAGE: read_hit = 5'h01;
      ADDR_RATE:           read_hit = 5'h02;
      ADDR_AUX_INPUT:      read_hit = 5'h04;
      ADDR_TEMPERATURE:    read_hit = 5'h08;
      ADDR_ANGLE:          read_hit = 5'h10;
      default:             read_hit = 5'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] clear_hit;
    logic       is_write;
    clear_hit  = 5'h00;
    is_write   = 1'b0;
    next_state = state;
    // Pin synchronisers shift on every clock; the write strobe is one cycle.
    next_state.cs_sync   = {state.cs_sync[1:0], link.cs_n};
    next_state.sclk_sync = {state.sclk_sync[1:0], link.sclk};
    next_state.mosi_sync = {state.mosi_sync[0], link.mosi};
    next_state.wr_strobe = 1'b0;

    // Chip select high resets the frame position.
    if (!cs_active) begin
      next_state.bit_count = 5'h00;                                   // RL3
    end
    // Rising edges assemble the input word, most significant bit first.
    if (sclk_rise) begin
      next_state.shift_in  = word_in;                                 // RL5
      next_state.bit_count = state.bit_count + 5'h01;
    end
    // Falling edges inside the frame move the reply on by one bit. The
    // trailing fall after the sixteenth rise finds the count at zero and
    // must leave alone the word that the frame end has just loaded.
    if (sclk_fall && (state.bit_count != 5'h00)) begin              // RL11
      next_state.miso      = state.shift_out[15];                     // RL21
      next_state.shift_out = {state.shift_out[14:0], 1'b0};
    end

    // End of frame: decode command and prepare the reply.
    if (frame_done) begin
      next_state.bit_count = 5'h00;
      is_write = word_in[CMD_WRITE_POS] & ~word_in[CMD_ZERO_POS];
      // A write stores its byte outside and sends zeros in the next frame.
      if (is_write) begin
        next_state.wr_addr   = word_in[ADDR_LSB +: ADDR_BITS];        // RL6
        next_state.wr_data   = word_in[BYTE_BITS-1:0];
        next_state.wr_strobe = 1'b1;
        next_state.shift_out = WORD_RESET;
      end else if (word_in[CMD_WRITE_POS:CMD_ZERO_POS] == 2'b00) begin
        // Low byte is don't care for reads.
        next_state.shift_out = read_mux(state, word_in[ADDR_LSB +: ADDR_BITS]); // RL8 RL9 RL11
        // The flag drops at request decode; the word latched above still
        // carries it set, so the host sees fresh data exactly once.
        clear_hit = read_hit(word_in[ADDR_LSB +: ADDR_BITS]);        // RL14
      end else begin
        // A frame that starts 0,1 or 1,1 is no command; it gets zeros back.
        next_state.shift_out = WORD_RESET;
      end
      // The first reply bit goes out at once; the rest follow the falls.
      next_state.miso = next_state.shift_out[15];
      next_state.shift_out = {next_state.shift_out[14:0], 1'b0};
    end

    // Sample refresh runs regardless of link activity; set wins over clear.
    next_state.new_data = state.new_data & ~clear_hit;
    if (sample_strobe_in) begin
      next_state.supply      = {2'b00, supply_sample_in};             // RL12 RL16
      next_state.rate        = rate_sample_in;                        // RL17 RL18
      next_state.aux         = {2'b00, aux_sample_in};
      next_state.temperature = {2'b00, temperature_sample_in};
      // The angle integrates the rate and wraps at its 14-bit field width.
      next_state.angle       = 14'(state.angle + rate_sample_in);
      next_state.new_data    = 5'h1f;                                 // RL14
    end
    // Clearing the angle wins over a same-cycle accumulate.
    if (angle_clear_in) begin
      next_state.angle = 14'h0000;                                    // RL20
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // The chip select stages start high, so no false frame follows reset, and
  // all output values start at zero, which clears the angle at power-up.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state         <= '0;                                            // RL20
      state.cs_sync <= 3'h7;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  // Data out is released while the synchronised chip select is high, which
  // lags the pin by two clocks at each end of a transaction.
  assign link.miso        = state.miso;
  assign link.miso_oe     = cs_active;                                // RL3
  assign write_addr_out   = state.wr_addr;
  assign write_data_out   = state.wr_data;
  assign write_strobe_out = state.wr_strobe;

endmodule : ssra_device

// ---- verilog/ssra_host.sv ----
// Purpose: Serial master issuing byte writes and pipelined register reads.
// Assumes: Commands come one at a time through a plain request port.
// Notes:   Each command is one frame; read data is the reply to the prior frame.
`timescale 1ns/1ps
module ssra_host
  import ssra_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  ssra_if.host             link,
  input  wire logic        cmd_valid_in,
  input  wire logic [1:0]  cmd_op_in,
  input  wire logic [5:0]  cmd_addr_in,
  input  wire logic [7:0]  cmd_data_in,
  output logic             cmd_ready_out,
  output logic [15:0]      reply_data_out,
  output logic             reply_valid_out
);

  typedef enum logic [1:0] {
    SSRA_H_IDLE  = 2'b00,
    SSRA_H_SHIFT = 2'b01,
    SSRA_H_GAP   = 2'b10
  } ssra_host_phase_t;

  typedef struct packed {
    ssra_host_phase_t phase;
    logic [1:0]       miso_sync;
    logic [15:0]      tx;
    logic [15:0]      rx;
    logic [4:0]       bits;
    logic [7:0]       timer;
    logic             sclk;
    logic             cs_n;
    logic [15:0]      reply;
    logic             reply_valid;
  } ssra_host_state_t;

  ssra_host_state_t state;
  ssra_host_state_t next_state;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.miso_sync   = {state.miso_sync[0], link.miso};
    next_state.reply_valid = 1'b0;
    unique case (state.phase)
      SSRA_H_IDLE: begin
        if (cmd_valid_in) begin
          next_state.cs_n  = 1'b0;                                    // RL2
          next_state.bits  = 5'h00;
          next_state.timer = 8'(SCLK_HALF_CYC - 1);
          next_state.phase = SSRA_H_SHIFT;
          if (cmd_op_in == SSRA_OP_WRITE) begin
            next_state.tx = {2'b10, cmd_addr_in, cmd_data_in};        // RL6 RL7
          end else begin
            next_state.tx = {2'b00, cmd_addr_in, 8'h00};              // RL8
          end
        end
      end
      SSRA_H_SHIFT: begin
        if (state.timer != 8'h00) begin
          next_state.timer = state.timer - 8'h01;
        end else begin
          next_state.timer = 8'(SCLK_HALF_CYC - 1);
          next_state.sclk  = ~state.sclk;
          if (!state.sclk) begin
            next_state.rx = {state.rx[14:0], state.miso_sync[1]};    // RL5
          end else begin
            next_state.tx   = {state.tx[14:0], 1'b0};                 // RL21
            next_state.bits = state.bits + 5'h01;
            if (state.bits == 5'(FRAME_BITS - 1)) begin              // RL4
              next_state.phase       = SSRA_H_GAP;
              next_state.timer       = 8'(CS_GAP_CYC);
              next_state.reply       = state.rx;                      // RL11
              next_state.reply_valid = 1'b1;
            end
          end
        end
      end
      SSRA_H_GAP: begin
        next_state.cs_n = 1'b1;
        if (state.timer != 8'h00) begin
          next_state.timer = state.timer - 8'h01;
        end else begin
          next_state.phase = SSRA_H_IDLE;
        end
      end
      default: next_state.phase = SSRA_H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state      <= '0;
      state.cs_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign link.cs_n       = state.cs_n;
  assign link.sclk       = state.sclk;
  assign link.mosi       = state.tx[15];
  assign cmd_ready_out   = (state.phase == SSRA_H_IDLE);
  assign reply_data_out  = state.reply;
  assign reply_valid_out = state.reply_valid;

endmodule : ssra_host
